//--- core/adc_trig_params.svh
// Constants of the converter pair trigger control block: offsets, field positions,
// reset values and selector codes. Included by every design file that needs them.
`ifndef ADC_TRIG_PARAMS_SVH
`define ADC_TRIG_PARAMS_SVH

`define ADC_PAIR_COUNT          6
`define ADC_ADDR_WIDTH          12

`define ADC_CTRL0_OFS           12'h000
`define ADC_CTRL1_OFS           12'h004
`define ADC_CTRL2_OFS           12'h008
`define ADC_IRQ_STATUS_OFS      12'h00C
`define ADC_IRQ_MASK_OFS        12'h010
`define ADC_GLOBAL_TRIG_OFS     12'h014
`define ADC_ENGINE_STATUS_OFS   12'h018

`define ADC_PAIR_SEL_LSB        0
`define ADC_PAIR_SEL_MSB        4
`define ADC_PAIR_SWTRIG_BIT     5
`define ADC_PAIR_PEND_BIT       6
`define ADC_PAIR_IRQEN_BIT      7
`define ADC_PAIR_HI_SHIFT       8

`define ADC_CTRL_RESET          16'h0000
`define ADC_FLAGS_RESET         6'h00

`define ADC_SEL_NONE            5'h00
`define ADC_SEL_SOFT_PAIR       5'h01
`define ADC_SEL_SOFT_GLOBAL     5'h02
`define ADC_SEL_SPECIAL_EVENT   5'h03
`define ADC_SEL_PRIMARY_FIRST   5'h04
`define ADC_SEL_PRIMARY_LAST    5'h07
`define ADC_SEL_TIMER1          5'h0C
`define ADC_SEL_SECONDARY_FIRST 5'h0E
`define ADC_SEL_SECONDARY_LAST  5'h11
`define ADC_SEL_CLIMIT_FIRST    5'h17
`define ADC_SEL_CLIMIT_LAST     5'h1A
`define ADC_SEL_TIMER2          5'h1F

`endif

//--- core/adc_trig_pkg.sv
// Types shared by the converter pair trigger control block.
// Assumes the constants header is compiled alongside.
package adc_trig_pkg;

    typedef enum logic [1:0] {
        ARB_IDLE  = 2'b00,
        ARB_ISSUE = 2'b01,
        ARB_WAIT  = 2'b11
    } arb_phase_t;

    typedef struct packed {
        arb_phase_t phase;
        logic [2:0] pair;
        logic       start;
    } arb_state_t;

    typedef struct packed {
        logic [5:0]       irq_enable;
        logic [5:0]       pending;
        logic [5:0]       soft_trigger;
        logic [5:0][4:0]  trigger_select;
        logic [5:0]       irq_status;
        logic [5:0]       irq_mask;
        logic             global_pulse;
        logic [31:0]      rdata;
        logic             ready;
        logic             slverr;
        logic             irq;
    } ctrl_state_t;

endpackage

//--- core/trig_if.sv
// Trigger event bundle passed from the top to each pair decoder.
// All events are one-cycle pulses synchronous to the block clock.
`timescale 1ns/1ps
interface trig_if;
    logic [3:0] primary;
    logic [3:0] secondary;
    logic [3:0] current_limit;
    logic       special_event;
    logic       timer1;
    logic       timer2;
    logic       global_soft;

    modport source (output primary, output secondary, output current_limit,
                    output special_event, output timer1, output timer2, output global_soft);
    modport sink   (input primary, input secondary, input current_limit,
                    input special_event, input timer1, input timer2, input global_soft);
endinterface // trig_if

//--- core/pair_trigger.sv
// Selector decoder of one channel pair: turns the selected event into a hit.
// Assumes events are single-cycle pulses; reserved codes never hit.
`timescale 1ns/1ps
`include "adc_trig_params.svh"
module pair_trigger (
    trig_if.sink      ev,
    input wire logic [4:0] select,
    input wire logic       soft_trigger,
    output logic           hit
);
    logic [4:0] offset;

    always_comb begin
        offset = 5'h00;
        hit    = 1'b0;
        if (select == `ADC_SEL_SOFT_PAIR) begin
            hit = soft_trigger;
        end else if (select == `ADC_SEL_SOFT_GLOBAL) begin
            hit = soft_trigger | ev.global_soft;
        end else if (select == `ADC_SEL_SPECIAL_EVENT) begin
            hit = ev.special_event;
        end else if (select >= `ADC_SEL_PRIMARY_FIRST && select <= `ADC_SEL_PRIMARY_LAST) begin
            offset = select - `ADC_SEL_PRIMARY_FIRST;
            hit    = ev.primary[offset[1:0]];
        end else if (select >= `ADC_SEL_SECONDARY_FIRST
                     && select <= `ADC_SEL_SECONDARY_LAST) begin
            offset = select - `ADC_SEL_SECONDARY_FIRST;
            hit    = ev.secondary[offset[1:0]];
        end else if (select >= `ADC_SEL_CLIMIT_FIRST && select <= `ADC_SEL_CLIMIT_LAST) begin
            offset = select - `ADC_SEL_CLIMIT_FIRST;
            hit    = ev.current_limit[offset[1:0]];
        end else if (select == `ADC_SEL_TIMER1) begin
            hit = ev.timer1;
        end else if (select == `ADC_SEL_TIMER2) begin
            hit = ev.timer2;
        end
        // Code zero and the reserved codes fall through with no hit.
    end
endmodule // pair_trigger

//--- core/conv_arbiter.sv
// Hands pending pairs one at a time to the shared conversion engine.
// Assumes the engine raises engine_done once for each start it accepted.
`timescale 1ns/1ps
`include "adc_trig_params.svh"
module conv_arbiter (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [5:0] pending,
    input  wire logic       engine_busy,
    input  wire logic       engine_done,
    output logic            engine_start,
    output logic [2:0]      engine_pair,
    output logic [5:0]      complete
);
    adc_trig_pkg::arb_state_t q;
    adc_trig_pkg::arb_state_t next_q;

    always_comb begin
        next_q       = q;
        next_q.start = 1'b0;
        unique case (q.phase)
            adc_trig_pkg::ARB_IDLE: begin
                // A request waits here while the engine serves someone else.
                if (|pending && !engine_busy) begin
                    for (int i = `ADC_PAIR_COUNT - 1; i >= 0; i--) begin
                        if (pending[i]) begin
                            next_q.pair = 3'(i);
                        end
                    end
                    next_q.start = 1'b1;
                    next_q.phase = adc_trig_pkg::ARB_ISSUE;
                end
            end
            adc_trig_pkg::ARB_ISSUE: begin
                next_q.phase = engine_done ? adc_trig_pkg::ARB_IDLE : adc_trig_pkg::ARB_WAIT;
            end
            adc_trig_pkg::ARB_WAIT: begin
                if (engine_done) begin
                    next_q.phase = adc_trig_pkg::ARB_IDLE;
                end
            end
            default: begin
                next_q.phase = adc_trig_pkg::ARB_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '{phase: adc_trig_pkg::ARB_IDLE, pair: 3'h0, start: 1'b0};
        end else begin
            q <= next_q;
        end
    end

    always_comb begin
        complete = 6'h00;
        if (q.phase != adc_trig_pkg::ARB_IDLE && engine_done) begin
            complete[q.pair] = 1'b1;
        end
    end

    assign engine_start = q.start;
    assign engine_pair  = q.pair;
endmodule // conv_arbiter

//--- core/adc_pair_trigger_control.sv
// Top of the converter pair trigger control block: APB register file, six pair
// decoders, pending tracking, interrupt status and the engine arbiter.
// Assumes APB3 signalling, pulse-shaped trigger events and one shared engine.
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "adc_trig_params.svh"

// Notes on behaviour
// - Selector 0 means no conversion, 1 the pair's own software trigger, 2 the global software trigger and 3 the special event trigger.
// - Selectors 4 to 7 pick the primary trigger of PWM generators 1 to 4.
// - Selectors 14 to 17 pick the secondary trigger of PWM generators 1 to 4.
// - Selectors 23 to 26 pick the current-limit trigger of PWM generators 1 to 4.
// - Selector 12 starts a conversion on a first timer period match.
// - Selector 31 starts a conversion on a second timer period match.
// - Reserved selector codes are not to be programmed and start nothing.
// - A finished conversion raises an interrupt request only when the pair's interrupt enable is one.
// - The pending bit sets when the selected trigger fires and clears once the conversion is done.
// - Writing one to the software trigger bit starts a conversion under a software selector, and hardware clears it when pending sets.
// - A request made while the engine is busy is held and served once the engine is free.
// - The third control register holds pair five as enable bit 15, pending bit 14, trigger bit 13 and selector bits 12 to 8.
// - The second control register holds the selector of pair two in bits 4 to 0.
// - The first control register holds the selector of pair one in bits 12 to 8.
module adc_pair_trigger_control (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [`ADC_ADDR_WIDTH-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic [3:0]                 pwm_primary_trigger,
    input  wire logic [3:0]                 pwm_secondary_trigger,
    input  wire logic [3:0]                 pwm_current_limit_trigger,
    input  wire logic                       pwm_special_event,
    input  wire logic                       timer1_period_match,
    input  wire logic                       timer2_period_match,
    input  wire logic                       engine_busy,
    input  wire logic                       engine_done,
    output logic                            engine_start,
    output logic      [2:0]                 engine_pair,
    output logic                            irq
);
    adc_trig_pkg::ctrl_state_t q;
    adc_trig_pkg::ctrl_state_t next_q;

    logic [5:0] hit;
    logic [5:0] complete;
    logic       access;
    logic       write_now;

    trig_if ev ();

    assign ev.primary       = pwm_primary_trigger;
    assign ev.secondary     = pwm_secondary_trigger;
    assign ev.current_limit = pwm_current_limit_trigger;
    assign ev.special_event = pwm_special_event;
    assign ev.timer1        = timer1_period_match;
    assign ev.timer2        = timer2_period_match;
    assign ev.global_soft   = q.global_pulse;

    for (genvar p = 0; p < `ADC_PAIR_COUNT; p++) begin : g_pair
        pair_trigger u_decode (
            .ev           (ev.sink),
            .select       (q.trigger_select[p]),
            .soft_trigger (q.soft_trigger[p]),
            .hit          (hit[p])
        );
    end

    conv_arbiter u_arbiter (
        .clk          (clk),
        .rst          (rst),
        .pending      (q.pending),
        .engine_busy  (engine_busy),
        .engine_done  (engine_done),
        .engine_start (engine_start),
        .engine_pair  (engine_pair),
        .complete     (complete)
    );

    // Packs one pair's fields into the byte layout shared by all pairs.
    function automatic logic [7:0] pair_byte(input adc_trig_pkg::ctrl_state_t s,
                                             input int p);
        logic [7:0] b;
        b = 8'h00;
        b[`ADC_PAIR_IRQEN_BIT]                      = s.irq_enable[p];
        b[`ADC_PAIR_PEND_BIT]                       = s.pending[p];
        b[`ADC_PAIR_SWTRIG_BIT]                     = s.soft_trigger[p];
        b[`ADC_PAIR_SEL_MSB:`ADC_PAIR_SEL_LSB]      = s.trigger_select[p];
        return b;
    endfunction

    // Read value of a control register holding pairs 2k (low byte) and 2k+1.
    function automatic logic [31:0] ctrl_word(input adc_trig_pkg::ctrl_state_t s,
                                              input int k);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[15:8] = pair_byte(s, 2 * k + 1);
        w[7:0]  = pair_byte(s, 2 * k);
        return w;
    endfunction

    assign access    = psel & penable;
    assign write_now = access & q.ready & pwrite;

    always_comb begin
        int         k;
        logic [7:0] wb;
        k            = 0;
        wb           = 8'h00;
        next_q       = q;
        next_q.global_pulse = 1'b0;

        // One wait state: pready rises in the second access cycle, and the
        // write lands on the edge that samples it high.
        if (access && !q.ready) begin
            next_q.ready  = 1'b1;
            next_q.slverr = 1'b0;
            next_q.rdata  = 32'h0000_0000;
            unique case (paddr)
                `ADC_CTRL0_OFS: begin
                    next_q.rdata = ctrl_word(q, 0);
                end
                `ADC_CTRL1_OFS: begin
                    next_q.rdata = ctrl_word(q, 1);
                end
                `ADC_CTRL2_OFS: begin
                    next_q.rdata = ctrl_word(q, 2);
                end
                `ADC_IRQ_STATUS_OFS: begin
                    next_q.rdata[5:0] = q.irq_status;
                end
                `ADC_IRQ_MASK_OFS: begin
                    next_q.rdata[5:0] = q.irq_mask;
                end
                `ADC_GLOBAL_TRIG_OFS: begin
                    next_q.rdata = 32'h0000_0000;
                end
                `ADC_ENGINE_STATUS_OFS: begin
                    next_q.rdata[5:0] = q.pending;
                    next_q.rdata[8]   = engine_busy;
                end
                default: begin
                    next_q.slverr = 1'b1;
                end
            endcase
        end else if (access && q.ready) begin
            next_q.ready  = 1'b0;
            next_q.slverr = 1'b0;
        end

        if (write_now) begin
            unique case (paddr)
                `ADC_CTRL0_OFS, `ADC_CTRL1_OFS, `ADC_CTRL2_OFS: begin
                    k = int'(paddr[3:2]);
                    for (int h = 0; h < 2; h++) begin
                        wb = pwdata[h * `ADC_PAIR_HI_SHIFT +: 8];
                        // Pending is status only; writes to it are dropped.
                        next_q.irq_enable[2 * k + h]     = wb[`ADC_PAIR_IRQEN_BIT];
                        next_q.soft_trigger[2 * k + h]   = wb[`ADC_PAIR_SWTRIG_BIT];
                        next_q.trigger_select[2 * k + h] =
                            wb[`ADC_PAIR_SEL_MSB:`ADC_PAIR_SEL_LSB];
                    end
                end
                `ADC_IRQ_STATUS_OFS: begin
                    next_q.irq_status = q.irq_status & ~pwdata[5:0];
                end
                `ADC_IRQ_MASK_OFS: begin
                    next_q.irq_mask = pwdata[5:0];
                end
                `ADC_GLOBAL_TRIG_OFS: begin
                    next_q.global_pulse = pwdata[0];
                end
                default: begin
                end
            endcase
        end

        for (int p = 0; p < `ADC_PAIR_COUNT; p++) begin
            // Completion clears first so that a trigger in the same cycle
            // leaves the pair pending again rather than being lost.
            if (complete[p]) begin
                next_q.pending[p] = 1'b0;
            end
            if (hit[p]) begin
                next_q.pending[p]      = 1'b1;
                next_q.soft_trigger[p] = 1'b0;
            end
            if (complete[p] && q.irq_enable[p]) begin
                next_q.irq_status[p] = 1'b1;
            end
        end

        next_q.irq = |(next_q.irq_status & next_q.irq_mask);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q.irq_enable     <= `ADC_FLAGS_RESET;
            q.pending        <= `ADC_FLAGS_RESET;
            q.soft_trigger   <= `ADC_FLAGS_RESET;
            q.trigger_select <= '0;
            q.irq_status     <= `ADC_FLAGS_RESET;
            q.irq_mask       <= `ADC_FLAGS_RESET;
            q.global_pulse   <= 1'b0;
            q.rdata          <= 32'h0000_0000;
            q.ready          <= 1'b0;
            q.slverr         <= 1'b0;
            q.irq            <= 1'b0;
        end else begin
            q <= next_q;
        end
    end

    assign prdata  = q.rdata;
    assign pready  = q.ready;
    assign pslverr = q.slverr;
    assign irq     = q.irq;
endmodule // adc_pair_trigger_control

//--- verif/adc_pair_trigger_control_monitor.sv
// Checker of the converter pair trigger control block, bound to its top module.
// Assumes it sees only the top ports and one clock domain with async reset.
`timescale 1ns/1ps
`include "adc_trig_params.svh"
module adc_pair_trigger_control_monitor (
    input wire logic                       clk,
    input wire logic                       rst,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [`ADC_ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0]                pwdata,
    input wire logic [31:0]                prdata,
    input wire logic                       pready,
    input wire logic                       pslverr,
    input wire logic                       engine_busy,
    input wire logic                       engine_done,
    input wire logic                       engine_start,
    input wire logic [2:0]                 engine_pair,
    input wire logic                       irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire wr_done = psel && penable && pwrite && pready;

    pready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    apb_answer_a: assert property ($rose(penable) && psel |=> pready)
        else $error("pready late after access phase");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    upper_zero_a: assert property (pready |-> prdata[31:16] == 16'h0000)
        else $error("upper read half not zero");
    start_pulse_a: assert property (engine_start |=> !engine_start)
        else $error("engine start longer than one cycle");
    start_after_done_a: assert property (engine_done |=> !engine_start)
        else $error("engine start in the cycle after done");
    pair_hold_a: assert property ($changed(engine_pair) |-> engine_start)
        else $error("engine pair changed without start");
    pair_range_a: assert property (engine_start |-> engine_pair <= 3'd5)
        else $error("engine pair out of range");
    irq_rise_a: assert property ($rose(irq) |-> $past(engine_done) || $past(wr_done))
        else $error("irq rose without done or write");
    irq_fall_a: assert property ($fell(irq) |-> $past(wr_done))
        else $error("irq fell without a register write");
endmodule // adc_pair_trigger_control_monitor

bind adc_pair_trigger_control adc_pair_trigger_control_monitor i_mon (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .engine_busy(engine_busy), .engine_done(engine_done),
    .engine_start(engine_start), .engine_pair(engine_pair), .irq(irq));

//--- verif/conv_engine_model.sv
// Behavioural model of the shared conversion engine beside the block.
// Assumes starts come only while idle; latency sets a prompt or slow answer.
`timescale 1ns/1ps
module conv_engine_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [7:0] latency,
    input  wire logic       engine_start,
    output logic            engine_busy,
    output logic            engine_done
);
    logic [7:0] left;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            engine_busy <= 1'b0;
            engine_done <= 1'b0;
            left        <= 8'h00;
        end else begin
            engine_done <= 1'b0;
            if (engine_start) begin
                engine_busy <= 1'b1;
                left        <= latency;
            end else if (engine_busy && left == 8'h00) begin
                engine_busy <= 1'b0;
                engine_done <= 1'b1;
            end else if (engine_busy) begin
                left <= left - 8'h01;
            end
        end
    end
endmodule // conv_engine_model

//--- verif/adc_pair_trigger_control_tb_top.sv
// Self-checking bench of the converter pair trigger control block.
// Assumes one-cycle trigger pulses and the engine model on the far side.
`timescale 1ns/1ps
`include "adc_trig_params.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module adc_pair_trigger_control_tb_top;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr, irq, perr;
    logic        engine_busy, engine_done, engine_start;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [14:0] ev;
    logic [2:0]  engine_pair;
    logic [7:0]  latency;
    logic [2:0]  starts[$];
    int          errors, checks;
    // Sources 0-14 are trigger pins, 15 the pair soft bit, 16 the global register.
    logic [4:0]  codes[18] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h0C,
                               5'h0E, 5'h0F, 5'h10, 5'h11, 5'h17, 5'h18, 5'h19, 5'h1A, 5'h1F,
                               5'h02};
    int          srcs[18]  = '{15, 16, 12, 0, 1, 2, 3, 13, 4, 5, 6, 7, 8, 9, 10, 11, 14, 15};
    logic [4:0]  rsv[7]    = '{5'h00, 5'h08, 5'h0B, 5'h0D, 5'h12, 5'h16, 5'h1B};

    adc_pair_trigger_control i_dut (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pwm_primary_trigger(ev[3:0]),
        .pwm_secondary_trigger(ev[7:4]), .pwm_current_limit_trigger(ev[11:8]),
        .pwm_special_event(ev[12]), .timer1_period_match(ev[13]),
        .timer2_period_match(ev[14]), .engine_busy(engine_busy),
        .engine_done(engine_done), .engine_start(engine_start),
        .engine_pair(engine_pair), .irq(irq));
    conv_engine_model i_eng (
        .clk(clk), .rst(rst), .latency(latency), .engine_start(engine_start),
        .engine_busy(engine_busy), .engine_done(engine_done));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) begin
        if (engine_start === 1'b1)
            starts.push_back(engine_pair);
    end

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Waits as long as the slave needs; only the watchdog ends a hang.
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        perr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h00000000);
        `CHK(nm, e, rd)
    endtask

    task automatic fire(input int s, input logic [4:0] c);
        if (s == 15)
            apb(1'b1, `ADC_CTRL0_OFS, {24'h000000, 3'b101, c});
        else if (s == 16)
            apb(1'b1, `ADC_GLOBAL_TRIG_OFS, 32'h00000001);
        else begin
            ev <= 15'h0001 << s;
            @(posedge clk);
            ev <= 15'h0000;
            @(posedge clk);
        end
    endtask

    task automatic t_reset();
        for (int a = 0; a < 7; a++)
            rdchk("reset_value", 12'(a * 4), 32'h00000000);
        `CHK("irq_reset", 1'b0, irq)
        $display("test reset done");
    endtask

    task automatic t_layout();
        apb(1'b1, `ADC_CTRL2_OFS, 32'hFFFFFFFF);
        rdchk("ctrl2_layout", `ADC_CTRL2_OFS, 32'h0000BFBF);
        apb(1'b1, `ADC_CTRL1_OFS, 32'h0000001F);
        rdchk("ctrl1_select", `ADC_CTRL1_OFS, 32'h0000001F);
        apb(1'b1, `ADC_CTRL0_OFS, 32'h00001F00);
        rdchk("ctrl0_select", `ADC_CTRL0_OFS, 32'h00001F00);
        rdchk("unmapped_read", 12'h020, 32'h00000000);
        `CHK("unmapped_err", 1'b1, perr)
        for (int a = 0; a < 3; a++)
            apb(1'b1, 12'(a * 4), 32'h00000000);
        $display("test layout done");
    endtask

    task automatic t_select();
        int n;
        apb(1'b1, `ADC_IRQ_MASK_OFS, 32'h0000003F);
        for (int i = 0; i < 18; i++) begin
            starts.delete();
            apb(1'b1, `ADC_CTRL0_OFS, {24'h000000, 3'b100, codes[i]});
            fire(srcs[i] == 12 ? 13 : 12, codes[i]);
            rdchk("no_false_hit", `ADC_ENGINE_STATUS_OFS, 32'h00000000);
            fire(srcs[i], codes[i]);
            n = 0;
            while (irq !== 1'b1 && n++ < 200)
                @(posedge clk);
            `CHK("irq_done", 1'b1, irq)
            `CHK("start_count", 1, starts.size())
            `CHK("start_pair", 3'd0, starts[0])
            rdchk("irq_status", `ADC_IRQ_STATUS_OFS, 32'h00000001);
            rdchk("ctrl_after", `ADC_CTRL0_OFS, {24'h000000, 3'b100, codes[i]});
            apb(1'b1, `ADC_IRQ_STATUS_OFS, 32'h00000001);
            `CHK("irq_clear", 1'b0, irq)
        end
        $display("test select done");
    endtask

    task automatic t_reserved();
        starts.delete();
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, `ADC_CTRL0_OFS, {24'h000000, 3'b100, rsv[i]});
            for (int s = 0; s < 17; s++)
                fire(s, rsv[i]);
            rdchk("reserved_idle", `ADC_ENGINE_STATUS_OFS, 32'h00000000);
        end
        `CHK("reserved_starts", 0, starts.size())
        apb(1'b1, `ADC_CTRL0_OFS, 32'h00000000);
        $display("test reserved done");
    endtask

    task automatic t_hold();
        int n;
        latency <= 8'd30;
        apb(1'b1, `ADC_CTRL0_OFS, 32'h0000008C);
        apb(1'b1, `ADC_CTRL1_OFS, 32'h00000C00);
        starts.delete();
        fire(13, 5'h00);
        rdchk("held_request", `ADC_ENGINE_STATUS_OFS, 32'h00000109);
        n = 0;
        do
            apb(1'b0, `ADC_ENGINE_STATUS_OFS, 32'h00000000);
        while (rd !== 32'h00000000 && n++ < 60);
        `CHK("hold_drained", 32'h00000000, rd)
        `CHK("hold_count", 2, starts.size())
        `CHK("hold_first", 3'd0, starts[0])
        `CHK("hold_second", 3'd3, starts[1])
        rdchk("irq_enable_only", `ADC_IRQ_STATUS_OFS, 32'h00000001);
        apb(1'b1, `ADC_IRQ_MASK_OFS, 32'h00000000);
        `CHK("irq_masked", 1'b0, irq)
        apb(1'b1, `ADC_IRQ_MASK_OFS, 32'h00000001);
        `CHK("irq_unmasked", 1'b1, irq)
        rdchk("mask_read", `ADC_IRQ_MASK_OFS, 32'h00000001);
        apb(1'b1, `ADC_IRQ_STATUS_OFS, 32'h00000001);
        `CHK("irq_cleared", 1'b0, irq)
        $display("test hold done");
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata, ev} = {1'b1, 62'h0};
        latency = 8'd4;
        errors = 0;
        checks = 0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_layout();
        t_select();
        t_reserved();
        t_hold();
        end_sim();
    end

    // The slowest path takes about a thousand cycles, so this limit leaves ample margin.
    initial begin
        repeat (40000) @(posedge clk);
        errors++;
        end_sim();
    end
endmodule // adc_pair_trigger_control_tb_top
